// ==== rtl/hifs_pkg.sv ====
/*
 host interface select front end: shared constants and types.
 assumes a single 50 MHz clock domain.
*/
`default_nettype none
package hifs_pkg;
   localparam int HIFS_CLK_HZ = 50000000;
   localparam int HIFS_SYNC_STAGES = 3;
   localparam int HIFS_BYTE_BITS = 8;
   localparam logic [3:0] HIFS_BITCNT_W_ZERO = 4'h0;
   localparam logic [3:0] HIFS_BITS_4W = 4'h8;
   localparam logic [3:0] HIFS_BITS_3W = 4'h9;
   localparam logic [7:0] HIFS_BYTE_RST = 8'h00;
   typedef enum logic [3:0] {
      HIFS_MODE_SPI4 = 4'h1,
      HIFS_MODE_SPI3 = 4'h2,
      HIFS_MODE_PAR_E = 4'h4,
      HIFS_MODE_PAR_S = 4'h8
   } hifs_mode_t;
   function automatic hifs_mode_t hifs_decode(input logic s0, input logic s1);
      unique case ({s1, s0})
         2'b01: hifs_decode = HIFS_MODE_SPI3;
         2'b00: hifs_decode = HIFS_MODE_SPI4;
         2'b11: hifs_decode = HIFS_MODE_PAR_E;
         default: hifs_decode = HIFS_MODE_PAR_S;
      endcase
   endfunction
endpackage
`default_nettype wire

// ==== rtl/hifs_sync.sv ====
/*
 three-stage synchroniser with agreement filter for a pin bundle.
 assumes inputs are asynchronous to ref_clk.
*/
`default_nettype none
module hifs_sync import hifs_pkg::*; #(
   parameter int W = 1
) (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic [W-1:0] pin,
   output logic [W-1:0] q
);
   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
      end else begin
         s1_r <= pin;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   // bits move only once stages two and three agree
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         q <= '0;
      end else begin
         for (int i = 0; i < W; i++) begin
            if (s2_r[i] == s3_r[i]) begin
               q[i] <= s3_r[i];
            end
         end
      end
   end
endmodule
`default_nettype wire

// ==== rtl/hifs_top.sv ====
/*
 host interface select front end: strap decode, serial shifters, parallel
 strobes, byte delivery tagged data or command, two general purpose pins.
 assumes the host is slow against ref_clk (sclk period 160 ns).
*/
// Function
// R1: straps select 3-wire serial (1,0), 4-wire serial (0,0), enable parallel (1,1), strobe parallel (0,1).
// R2: while reset_n_in is low the controller logic is held in initialisation.
// R3: the host keeps reset_n_in high in normal operation.
// R4: transfers are accepted only while chip select is low.
// R5: in parallel modes a byte is data when dc is high and command when low.
// R6: in 4-wire serial the dc pin classifies the shifted byte the same way.
// R7: in 3-wire serial the dc pin is tied to ground.
// R8: two general purpose pins can be inputs or outputs.
// R9: in serial modes data line 1 is serial_in and data line 0 is the serial clock.
// R10: enable parallel starts a transfer on enable high with chip select low; rw high reads.
// R11: in 3-wire serial a leading flag bit gives data or command ahead of eight payload bits.
`default_nettype none
module hifs_top import hifs_pkg::*; (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic iface_sel0,
   input wire logic iface_sel1,
   input wire logic reset_n_in,
   input wire logic cs_n,
   input wire logic dc,
   input wire logic en_rd_n,
   input wire logic rw_wr_n,
   input wire logic [7:0] d_in,
   output logic [7:0] d_out,
   output logic d_oe_n,
   input wire logic [7:0] rd_byte,
   output logic init_busy,
   output logic [3:0] mode,
   output logic [7:0] rx_byte,
   output logic rx_is_data,
   output logic rx_valid,
   output logic rd_req,
   input wire logic [1:0] gen_pin_in,
   output logic [1:0] gen_pin_out,
   output logic [1:0] gen_pin_oe_n,
   input wire logic [1:0] gen_out_val,
   input wire logic [1:0] gen_out_en,
   output logic [1:0] gen_in_val
);
   logic [16:0] pins_raw;
   logic [16:0] pins_s;
   logic res_n_s;
   logic csn_s;
   logic dc_s;
   logic e_s;
   logic rw_s;
   logic [7:0] d_s;
   logic [1:0] gp_s;
   logic sel0_s;
   logic sel1_s;
   logic e_q_r;
   logic rw_q_r;
   logic sclk_q_r;
   hifs_mode_t mode_r;
   logic [3:0] bitcnt_r;
   logic [8:0] shift_r;
   logic active;

   // straps are pins too: they share the pipeline with reset_n_in, so both move together
   assign pins_raw = {iface_sel1, iface_sel0, gen_pin_in, d_in, rw_wr_n, en_rd_n, dc, cs_n,
      reset_n_in};
   hifs_sync #(.W(17)) u_sync (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .pin(pins_raw),
      .q(pins_s)
   );
   assign {sel1_s, sel0_s, gp_s, d_s, rw_s, e_s, dc_s, csn_s, res_n_s} = pins_s;
   assign active = res_n_s && !csn_s; // R4

   // straps are sampled while reset_n_in is low, frozen afterwards
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         mode_r <= HIFS_MODE_SPI4;
         init_busy <= 1'b1;
      end else begin
         init_busy <= !res_n_s; // R2
         if (!res_n_s) begin
            mode_r <= hifs_decode(sel0_s, sel1_s); // R1
         end
      end
   end
   assign mode = mode_r;

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         e_q_r <= 1'b0;
         rw_q_r <= 1'b1;
         sclk_q_r <= 1'b0;
      end else begin
         e_q_r <= e_s;
         rw_q_r <= rw_s;
         sclk_q_r <= d_s[0];
      end
   end

   // serial shifter, msb first; cs high aborts a partial byte
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         bitcnt_r <= HIFS_BITCNT_W_ZERO;
         shift_r <= '0;
      end else if (!active || !(mode_r == HIFS_MODE_SPI3 || mode_r == HIFS_MODE_SPI4)) begin
         bitcnt_r <= HIFS_BITCNT_W_ZERO; // R4
      end else if (d_s[0] && !sclk_q_r) begin
         shift_r <= {shift_r[7:0], d_s[1]}; // R9
         if ((mode_r == HIFS_MODE_SPI3 && bitcnt_r == HIFS_BITS_3W - 4'h1) ||
             (mode_r == HIFS_MODE_SPI4 && bitcnt_r == HIFS_BITS_4W - 4'h1)) begin
            bitcnt_r <= HIFS_BITCNT_W_ZERO;
         end else begin
            bitcnt_r <= bitcnt_r + 4'h1;
         end
      end
   end

   logic ser_done;
   logic par_wr;
   logic par_rd;
   assign ser_done = active && d_s[0] && !sclk_q_r &&
      ((mode_r == HIFS_MODE_SPI3 && bitcnt_r == HIFS_BITS_3W - 4'h1) ||
       (mode_r == HIFS_MODE_SPI4 && bitcnt_r == HIFS_BITS_4W - 4'h1));
   // enable mode: latch on falling enable; strobe mode: on rising write strobe
   assign par_wr = active && ((mode_r == HIFS_MODE_PAR_E && e_q_r && !e_s && !rw_s) || // R10
      (mode_r == HIFS_MODE_PAR_S && !rw_q_r && rw_s));
   assign par_rd = active && ((mode_r == HIFS_MODE_PAR_E && !e_q_r && e_s && rw_s) || // R10
      (mode_r == HIFS_MODE_PAR_S && e_q_r && !e_s));

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         rx_valid <= 1'b0;
         rx_byte <= HIFS_BYTE_RST;
         rx_is_data <= 1'b0;
      end else begin
         rx_valid <= ser_done || par_wr;
         if (par_wr) begin
            rx_byte <= d_s;
            rx_is_data <= dc_s; // R5
         end else if (ser_done) begin
            rx_byte <= {shift_r[6:0], d_s[1]};
            if (mode_r == HIFS_MODE_SPI3) begin
               rx_is_data <= shift_r[7]; // R11 R7
            end else begin
               rx_is_data <= dc_s; // R6
            end
         end
      end
   end

   // read drive: bus driven while the read phase lasts
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         rd_req <= 1'b0;
         d_oe_n <= 1'b1;
         d_out <= HIFS_BYTE_RST;
      end else begin
         rd_req <= par_rd;
         d_out <= rd_byte;
         d_oe_n <= !(active && ((mode_r == HIFS_MODE_PAR_E && e_s && rw_s) ||
            (mode_r == HIFS_MODE_PAR_S && !e_s)));
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         gen_pin_out <= 2'h0;
         gen_pin_oe_n <= 2'h3;
         gen_in_val <= 2'h0;
      end else begin
         gen_pin_out <= gen_out_val; // R8
         gen_pin_oe_n <= ~gen_out_en;
         gen_in_val <= gp_s;
      end
   end

   chk_ser_gate: assert property (@(posedge ref_clk) disable iff (!rstn)
      !active |=> !rx_valid && !rd_req) // R4
      else $error("byte accepted while deselected");
   chk_init_flag: assert property (@(posedge ref_clk) disable iff (!rstn)
      !res_n_s |=> init_busy) // R2
      else $error("init flag missing");
   chk_mode_hold: assert property (@(posedge ref_clk) disable iff (!rstn)
      res_n_s |=> $stable(mode_r)) // R1
      else $error("mode changed outside reset");
   chk_par_dc: assert property (@(posedge ref_clk) disable iff (!rstn)
      par_wr |=> rx_valid && rx_is_data == $past(dc_s) && rx_byte == $past(d_s)) // R5
      else $error("parallel byte wrong");
   chk_spi4_dc: assert property (@(posedge ref_clk) disable iff (!rstn)
      ser_done && mode_r == HIFS_MODE_SPI4 |=> rx_is_data == $past(dc_s)) // R6
      else $error("4-wire class wrong");
   chk_spi3_flag: assert property (@(posedge ref_clk) disable iff (!rstn)
      ser_done && mode_r == HIFS_MODE_SPI3 |=> rx_is_data == $past(shift_r[7])) // R11
      else $error("3-wire flag wrong");
   // read request: one cycle high, then low again
   sequence hifs_rd_pulse;
      rd_req ##1 !rd_req;
   endsequence
   chk_rd_strobe: assert property (@(posedge ref_clk) disable iff (!rstn)
      par_rd |=> hifs_rd_pulse) // R10
      else $error("read request not a pulse");
   chk_rd_drive: assert property (@(posedge ref_clk) disable iff (!rstn)
      !active |=> d_oe_n) // R4
      else $error("bus driven while deselected");
   chk_ser_clear: assert property (@(posedge ref_clk) disable iff (!rstn)
      !active |=> bitcnt_r == HIFS_BITCNT_W_ZERO) // R4
      else $error("partial byte kept");
   chk_rd_data: assert property (@(posedge ref_clk) disable iff (!rstn)
      !d_oe_n |-> d_out == $past(rd_byte)) // R10
      else $error("read byte wrong");
   chk_init_end: assert property (@(posedge ref_clk) disable iff (!rstn)
      res_n_s |=> !init_busy) // R2
      else $error("init flag stuck");
   chk_serial_bit: assert property (@(posedge ref_clk) disable iff (!rstn)
      ser_done |=> rx_byte[0] == $past(d_s[1])) // R9
      else $error("serial bit lost");
   chk_gen_out: assert property (@(posedge ref_clk) disable iff (!rstn)
      1'b1 |=> gen_pin_oe_n == ~$past(gen_out_en)) // R8
      else $error("gen pin enable wrong");
endmodule
`default_nettype wire

// ==== bench/hifs_host.sv ====
/*
 host model: drives chip select, dc, strobes and data pins in all modes.
 assumes the caller has latched the matching strap code first.
*/
`default_nettype none
module hifs_host import hifs_pkg::*; (
   input wire logic ref_clk,
   input wire logic [7:0] d_out,
   input wire logic d_oe_n,
   output logic cs_n,
   output logic dc,
   output logic en_rd_n,
   output logic rw_wr_n,
   output logic [7:0] d_in
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      cs_n = 1'b1;
      dc = 1'b0;
      en_rd_n = 1'b0;
      rw_wr_n = 1'b0;
      d_in = 8'h00;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   // sel low keeps cs_n high: the byte must be ignored
   task automatic send(input logic [3:0] m, input logic f, input logic [7:0] b,
                       input logic sel);
      logic [8:0] w;
      int n;
      w = {f, b};
      n = (m == HIFS_MODE_SPI3) ? 9 : 8;
      @(posedge ref_clk);
      rw_wr_n <= m[3];
      en_rd_n <= m[3];
      dc <= (m == HIFS_MODE_SPI3) ? 1'b0 : f;
      tick(8);
      // strobes settle before select falls, so no false edge is taken
      cs_n <= ~sel;
      tick(8);
      if (m[3:2] == 2'b00) begin
         for (int i = n - 1; i >= 0; i--) begin
            d_in <= {6'h00, w[i], 1'b0};
            tick(4);
            d_in[0] <= 1'b1;
            tick(4);
         end
         // clock stands low, data line no longer shows the last bit
         d_in <= {6'h00, ~w[0], 1'b0};
      end else begin
         d_in <= b;
         rw_wr_n <= 1'b0;
         // enable high, or read strobe left idle
         en_rd_n <= 1'b1;
         tick(8);
         rw_wr_n <= m[3];
         en_rd_n <= m[3];
         tick(8);
         d_in <= ~b;
      end
      tick(2);
      cs_n <= 1'b1;
      dc <= (m == HIFS_MODE_SPI3) ? 1'b0 : ~f;
   endtask
   // parallel read: b is the bus at the end of the read phase, drv whether it was driven
   task automatic recv(input logic [3:0] m, input logic sel, output logic [7:0] b,
                       output logic drv);
      @(posedge ref_clk);
      rw_wr_n <= 1'b1;
      en_rd_n <= m[3];
      tick(8);
      cs_n <= ~sel;
      tick(8);
      en_rd_n <= ~m[3];
      tick(8);
      b = d_out;
      drv = ~d_oe_n;
      en_rd_n <= m[3];
      tick(8);
      cs_n <= 1'b1;
   endtask
   // serial frame cut after k clocks
   task automatic partial(input int k);
      @(posedge ref_clk);
      rw_wr_n <= 1'b0;
      en_rd_n <= 1'b0;
      cs_n <= 1'b0;
      tick(8);
      repeat (k) begin
         d_in <= 8'h02;
         tick(4);
         d_in[0] <= 1'b1;
         tick(4);
      end
      d_in <= 8'h00;
      tick(4);
      cs_n <= 1'b1;
   endtask
endmodule
`default_nettype wire

// ==== bench/hifs_top_tb.sv ====
/*
 bench for hifs_top: strap modes, serial and parallel writes, chip select, spare pins.
 assumes hifs_host drives the host side pins.
*/
`default_nettype none
module hifs_top_tb import hifs_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk, rstn, iface_sel0, iface_sel1, reset_n_in, cs_n, dc, en_rd_n, rw_wr_n;
   logic d_oe_n, init_busy, rx_is_data, rx_valid, got_d;
   logic [7:0] d_in, d_out, rx_byte, got_b;
   logic [3:0] mode;
   logic [1:0] gen_pin_in, gen_pin_out, gen_pin_oe_n, gen_out_val, gen_out_en, gen_in_val;
   int got_n, failures, check_count;
   logic rd_req, rd_oe;
   logic [7:0] rd_byte, rd_seen;
   int rd_n;
   hifs_top DUT (.ref_clk, .rstn, .iface_sel0, .iface_sel1, .reset_n_in, .cs_n, .dc,
      .en_rd_n, .rw_wr_n, .d_in, .d_out, .d_oe_n, .rd_byte, .init_busy, .mode,
      .rx_byte, .rx_is_data, .rx_valid, .rd_req, .gen_pin_in, .gen_pin_out,
      .gen_pin_oe_n, .gen_out_val, .gen_out_en, .gen_in_val);
   hifs_host host (.ref_clk, .d_out, .d_oe_n, .cs_n, .dc, .en_rd_n, .rw_wr_n, .d_in);
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   // rx_valid lasts one cycle, so every edge is watched
   always @(posedge ref_clk) begin
      if (rx_valid === 1'b1) begin
         got_n <= got_n + 1;
         got_b <= rx_byte;
         got_d <= rx_is_data;
      end
      if (rd_req === 1'b1) begin
         rd_n <= rd_n + 1;
      end
   end
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      check_count++;
      if (g !== e) begin
         failures++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic t_mode(input logic s0, input logic s1, input logic [3:0] m);
      reset_n_in <= 1'b0;
      iface_sel0 <= s0;
      iface_sel1 <= s1;
      host.tick(12);
      chk("init_busy", 8'h01, {7'h00, init_busy});
      reset_n_in <= 1'b1;
      host.tick(12);
      chk("mode", {4'h0, m}, {4'h0, mode});
      chk("init_busy", 8'h00, {7'h00, init_busy});
   endtask
   task automatic t_xfer(input logic [3:0] m, input logic f, input logic [7:0] b,
                         input logic sel);
      int n0;
      n0 = got_n;
      host.send(m, f, b, sel);
      host.tick(10);
      chk("count", 8'(n0 + int'(sel)), 8'(got_n));
      chk("d_oe_n", 8'h01, {7'h00, d_oe_n});
      if (sel) begin
         chk("rx_byte", b, got_b);
         chk("rx_is_data", {7'h00, f}, {7'h00, got_d});
      end
   endtask
   task automatic t_read(input logic [3:0] m, input logic [7:0] v, input logic sel);
      int r0;
      r0 = rd_n;
      rd_byte <= v;
      host.recv(m, sel, rd_seen, rd_oe);
      host.tick(10);
      chk("rd_count", 8'(r0 + int'(sel)), 8'(rd_n));
      chk("rd_drive", {7'h00, sel}, {7'h00, rd_oe});
      chk("d_oe_n", 8'h01, {7'h00, d_oe_n});
      if (sel) begin
         chk("d_out", v, rd_seen);
      end
   endtask
   task automatic t_abort(input int k);
      int n0;
      n0 = got_n;
      host.partial(k);
      host.tick(10);
      chk("abort_count", 8'(n0), 8'(got_n));
   endtask
   task automatic t_gen();
      gen_out_val <= 2'b10;
      gen_out_en <= 2'b01;
      gen_pin_in <= 2'b01;
      host.tick(8);
      chk("gen_pin_out", 8'h02, {6'h00, gen_pin_out});
      chk("gen_pin_oe_n", 8'h02, {6'h00, gen_pin_oe_n});
      chk("gen_in_val", 8'h01, {6'h00, gen_in_val});
   endtask
   task automatic end_of_test();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial begin
      #200us;
      failures++;
      end_of_test();
   end
   initial begin
      rstn = 1'b0;
      {iface_sel0, iface_sel1, reset_n_in} = 3'h0;
      {gen_pin_in, gen_out_val, gen_out_en} = 6'h00;
      {got_n, failures, check_count} = {32'h0, 32'h0, 32'h0};
      rd_n = 0;
      rd_byte = 8'h00;
      repeat (2) @(posedge ref_clk);
      rstn <= 1'b1;
      t_mode(1'b0, 1'b0, HIFS_MODE_SPI4);
      t_xfer(HIFS_MODE_SPI4, 1'b1, 8'ha5, 1'b1);
      t_abort(5);
      t_xfer(HIFS_MODE_SPI4, 1'b0, 8'h81, 1'b1);
      t_xfer(HIFS_MODE_SPI4, 1'b1, 8'h3c, 1'b0);
      t_mode(1'b1, 1'b0, HIFS_MODE_SPI3);
      t_xfer(HIFS_MODE_SPI3, 1'b1, 8'h5a, 1'b1);
      t_abort(4);
      t_xfer(HIFS_MODE_SPI3, 1'b0, 8'hc3, 1'b1);
      t_mode(1'b1, 1'b1, HIFS_MODE_PAR_E);
      t_xfer(HIFS_MODE_PAR_E, 1'b1, 8'h96, 1'b1);
      t_xfer(HIFS_MODE_PAR_E, 1'b0, 8'h01, 1'b1);
      t_xfer(HIFS_MODE_PAR_E, 1'b0, 8'h42, 1'b0);
      t_read(HIFS_MODE_PAR_E, 8'h6d, 1'b1);
      t_read(HIFS_MODE_PAR_E, 8'h24, 1'b0);
      t_mode(1'b0, 1'b1, HIFS_MODE_PAR_S);
      t_xfer(HIFS_MODE_PAR_S, 1'b1, 8'h7e, 1'b1);
      t_xfer(HIFS_MODE_PAR_S, 1'b0, 8'h80, 1'b1);
      t_read(HIFS_MODE_PAR_S, 8'hb2, 1'b1);
      t_gen();
      end_of_test();
   end
endmodule
`default_nettype wire
